// >>> logic/ldt_defines.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * link diagnostic block (quality thresholds, reflectometry, self test).
 * Assumes inclusion by bare name from the design files and the bench.
 */
`ifndef LDT_DEFINES_SVH
`define LDT_DEFINES_SVH

// Management register offsets
`define LDT_OFF_RCTRL 5'h16
`define LDT_OFF_RWIN 5'h17
`define LDT_OFF_RPEAK 5'h18
`define LDT_OFF_RTHR 5'h19
`define LDT_OFF_DIAG 5'h1B
`define LDT_OFF_QMON 5'h1D
`define LDT_OFF_QDATA 5'h1E

// Reflection control fields
`define LDT_B_ENABLE 15
`define LDT_B_FAST 14
`define LDT_B_DRVPAIR 13
`define LDT_B_MONPAIR 12
`define LDT_B_SEND 11
`define LDT_B_MINMODE 7

// Threshold data, monitor control and diagnostic fields
`define LDT_B_THRWR 12
`define LDT_B_SAMPLE 13
`define LDT_B_QENABLE 15
`define LDT_B_CONT 5
`define LDT_SNR_SEL 4'hA

// Reset values
`define LDT_RST_RWIN 16'h00FF
`define LDT_S8_MIN 8'h80
`define LDT_S8_MAX 8'h7F
`define LDT_U8_MIN 8'h00
`define LDT_U8_MAX 8'hFF
`define LDT_SNR_MAX_BYTE 8'h90
`define LDT_SNR_MAX {`LDT_SNR_MAX_BYTE, 4'h0}
`define LDT_PRBS_INIT 15'h7FFF

// Timing
`define LDT_CLK_NS 10
`define LDT_SLOW_SHORT_NS 50
`define LDT_SLOW_LONG_NS 100
`define LDT_SLOW_SHORT_CYC (`LDT_SLOW_SHORT_NS / `LDT_CLK_NS)
`define LDT_SLOW_LONG_CYC (`LDT_SLOW_LONG_NS / `LDT_CLK_NS)
`define LDT_MON_LAST 8'hFF
`define LDT_BIST_SEED 4'hF

`endif

// >>> logic/ldt_pkg.sv
/*
 * Types of the link diagnostic block: carriers and the state record.
 * Assumes the defines header sits beside it.
 */
`default_nettype none
package ldt_pkg;

    // Adapted values handed in by the line equaliser
    typedef struct packed {
        logic [7:0] eq;
        logic [7:0] gain;
        logic [7:0] blw;
        logic [7:0] freq;
        logic [7:0] fc;
        logic [11:0] snr;
    } ldt_params_type;

    // One management access
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic write;
        logic read;
    } ldt_regreq_type;

    typedef enum logic [1:0] {TDR_IDLE, TDR_RUN, TDR_HOLD} ldt_tdr_type;

    typedef struct packed {
        logic [15:0] rctrl;
        logic [15:0] rwin;
        logic [15:0] rdData;
        logic [10:0][7:0] thr;
        logic [3:0] qSel;
        logic sampleMode;
        logic [7:0] sampleVal;
        logic qEnable;
        logic [10:0] warn;
        logic irq;
        ldt_tdr_type tdr;
        logic [7:0] pulseCnt;
        logic pulseFast;
        logic pulseSlow;
        logic pulseNeg;
        logic [7:0] tick;
        logic peakSeen;
        logic [7:0] peakVal;
        logic [7:0] peakTime;
        logic thrHit;
        logic [7:0] thrTime;
        logic cont;
        logic [7:0] errCnt;
        logic pass;
        logic failLatched;
        logic [3:0] seedCnt;
        logic [12:0] burstCnt;
        logic txBit;
        logic txValid;
    } ldt_state_type;

endpackage
`default_nettype wire

// >>> logic/ldt_prbs.sv
/*
 * Pseudo-random sequence register, 9 or 15 stages. Free running when fed
 * its own prediction, self synchronising when fed received bits.
 * Assumes the caller steps it once per bit on the main clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ldt_defines.svh"
module ldt_prbs (
    input wire logic clock,
    input wire logic nrst,
    input wire logic shiftEn,
    input wire logic longSeq,
    input wire logic feedSelf,
    input wire logic inBit,
    output logic predBit
);
    import ldt_pkg::*;
    logic [14:0] lfsr;
    logic [14:0] next_lfsr;

    // Taps x9+x5+1 or x15+x14+1
    assign predBit = longSeq ? (lfsr[14] ^ lfsr[13]) : (lfsr[8] ^ lfsr[4]);

    // Shift in either the prediction or the received bit
    always_comb begin
        next_lfsr = lfsr;
        if (shiftEn) begin
            next_lfsr = {lfsr[13:0], feedSelf ? predBit : inBit};
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lfsr <= `LDT_PRBS_INIT;
        end else begin
            lfsr <= next_lfsr;
        end
    end
endmodule
`default_nettype wire

// >>> logic/ldt_top.sv
/*
 * Link diagnostics: quality thresholds with indirect access, reflectometry
 * pulse engine and monitor, pseudo-random self test with error count.
 * Assumes equaliser values, converter samples and loopback bits arrive on
 * this clock; register accesses come as single-cycle strobes.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ldt_defines.svh"
module ldt_top (
    input wire logic clock,
    input wire logic nrst,
    input wire ldt_pkg::ldt_regreq_type regReq,
    output logic [15:0] regRdData,
    input wire ldt_pkg::ldt_params_type params,
    input wire logic irqEnable,
    output logic qualityIrq,
    input wire logic [7:0] adcSample,
    input wire logic adcStrobe,
    output logic tdrOwnsDrivers,
    output logic fastDriverPulse,
    output logic slowDriverPulse,
    output logic pulseNegative,
    output logic drivePairRx,
    output logic monitorPairRx,
    input wire logic bistRun,
    input wire logic bistStartWrite,
    input wire logic longSequenceSelect,
    input wire logic rxBit,
    input wire logic rxValid,
    output logic txBit,
    output logic txValid,
    output logic bistPass
);
    import ldt_pkg::*;

    ldt_state_type st;
    ldt_state_type next_st;
    logic launch;
    logic inWindow;
    logic signed [8:0] level;
    logic [10:0] rawWarn;
    logic txPred;
    logic rxPred;
    logic checkBit;

    // Byte of the adapted parameter chosen by a three-bit selector
    function automatic logic [7:0] paramByte(input ldt_params_type p, input logic [2:0] sel);
        case (sel)
            3'h0: paramByte = p.eq;
            3'h1: paramByte = p.gain;
            3'h2: paramByte = p.blw;
            3'h3: paramByte = p.freq;
            default: paramByte = p.fc;
        endcase
    endfunction

    // Strict comparisons; equality never warns
    function automatic logic above(input logic [7:0] v, input logic [7:0] t, input logic sgn);
        above = sgn ? ($signed(v) > $signed(t)) : (v > t);
    endfunction

    function automatic logic below(input logic [7:0] v, input logic [7:0] t, input logic sgn);
        below = sgn ? ($signed(v) < $signed(t)) : (v < t);
    endfunction

    // Nine bits so that negating -128 cannot wrap
    function automatic logic signed [8:0] orient(input logic [7:0] v, input logic neg);
        orient = neg ? -$signed({v[7], v}) : $signed({v[7], v});
    endfunction

    assign launch = st.rctrl[`LDT_B_ENABLE] & st.rctrl[`LDT_B_SEND];
    assign inWindow = (st.tick >= st.rwin[15:8]) && (st.tick <= st.rwin[7:0]);
    assign level = orient(adcSample, st.rctrl[`LDT_B_MINMODE]);
    assign checkBit = bistRun && rxValid && (st.seedCnt == `LDT_BIST_SEED);

    // Warning compare per threshold, gain and SNR unsigned, the rest signed
    always_comb begin
        rawWarn = '0;
        for (int i = 0; i < 5; i++) begin
            rawWarn[2 * i] = below(paramByte(params, 3'(i)), st.thr[2 * i], i != 1);
            rawWarn[2 * i + 1] = above(paramByte(params, 3'(i)), st.thr[2 * i + 1], i != 1);
        end
        rawWarn[10] = params.snr > {st.thr[10], 4'h0};
    end

    // Transmit sequence runs on its own prediction
    ldt_prbs txGen (
        .clock(clock),
        .nrst(nrst),
        .shiftEn(next_st.txValid),
        .longSeq(longSequenceSelect),
        .feedSelf(1'b1),
        .inBit(1'b0),
        .predBit(txPred)
    );

    // Checker locks onto the received stream, then predicts each bit
    ldt_prbs rxChk (
        .clock(clock),
        .nrst(nrst),
        .shiftEn(bistRun && rxValid),
        .longSeq(longSequenceSelect),
        .feedSelf(1'b0),
        .inBit(rxBit),
        .predBit(rxPred)
    );

    // Whole next state of the block
    always_comb begin
        next_st = st;
        // Register writes
        if (regReq.write) begin
            case (regReq.addr)
                `LDT_OFF_RCTRL: next_st.rctrl = regReq.wdata;
                `LDT_OFF_RWIN: next_st.rwin = regReq.wdata;
                `LDT_OFF_DIAG: next_st.cont = regReq.wdata[`LDT_B_CONT];
                `LDT_OFF_QMON: next_st.qEnable = regReq.wdata[`LDT_B_QENABLE];
                `LDT_OFF_QDATA: begin
                    if (regReq.wdata[`LDT_B_THRWR]) begin
                        next_st.thr[regReq.wdata[11:8]] = regReq.wdata[7:0];
                        next_st.qSel = regReq.wdata[11:8];
                        next_st.sampleMode = 1'b0;
                    end else if (regReq.wdata[`LDT_B_SAMPLE]) begin
                        next_st.sampleVal = paramByte(params, regReq.wdata[11:9]);
                        next_st.qSel = {1'b0, regReq.wdata[11:9]};
                        next_st.sampleMode = 1'b1;
                    end else begin
                        next_st.qSel = regReq.wdata[11:8];
                        next_st.sampleMode = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Register reads, one cycle later on regRdData
        if (regReq.read) begin
            case (regReq.addr)
                `LDT_OFF_RCTRL: next_st.rdData = st.rctrl;
                `LDT_OFF_RWIN: next_st.rdData = st.rwin;
                `LDT_OFF_RPEAK: next_st.rdData = {st.peakTime, st.peakVal};
                `LDT_OFF_RTHR: next_st.rdData = {st.thrTime, st.thrHit, 7'h00};
                `LDT_OFF_DIAG: next_st.rdData = {st.errCnt, 2'b00, st.cont, 5'h00};
                `LDT_OFF_QMON: next_st.rdData = {st.qEnable, 4'h0, st.warn};
                `LDT_OFF_QDATA: begin
                    if (st.sampleMode) begin
                        next_st.rdData = {4'h0, st.qSel, st.sampleVal};
                    end else begin
                        next_st.rdData = {4'h0, st.qSel, st.thr[st.qSel]};
                    end
                end
                default: next_st.rdData = 16'h0000;
            endcase
        end
        // Sticky warnings clear on read; a new warning in that cycle wins
        if (regReq.read && regReq.addr == `LDT_OFF_QMON) begin
            next_st.warn = '0;
        end
        if (st.qEnable) begin
            next_st.warn = next_st.warn | rawWarn;
        end
        next_st.irq = irqEnable && (|st.warn);

        // Reflectometry engine
        if (!next_st.rctrl[`LDT_B_ENABLE]) begin
            next_st.tdr = TDR_IDLE;
            next_st.pulseFast = 1'b0;
            next_st.pulseSlow = 1'b0;
        end else if (launch) begin
            next_st.rctrl[`LDT_B_SEND] = next_st.rctrl[`LDT_B_SEND] & regReq.write & (regReq.addr == `LDT_OFF_RCTRL);
            next_st.tdr = TDR_RUN;
            next_st.tick = 8'h00;
            next_st.peakSeen = 1'b0;
            next_st.thrHit = 1'b0;
            next_st.peakVal = 8'h00;
            next_st.peakTime = 8'h00;
            next_st.thrTime = 8'h00;
            next_st.pulseFast = 1'b0;
            next_st.pulseSlow = 1'b0;
            next_st.pulseCnt = 8'h00;
            if (st.rctrl[10:8] != 3'h0) begin
                if (st.rctrl[`LDT_B_FAST]) begin
                    next_st.pulseFast = 1'b1;
                    next_st.pulseNeg = ~st.pulseNeg;
                    next_st.pulseCnt = {5'h00, st.rctrl[10:8]};
                end else begin
                    next_st.pulseSlow = 1'b1;
                    // Polarity left alone so fast pulses keep alternating across slow ones
                    next_st.pulseCnt = st.rctrl[10] ? 8'(`LDT_SLOW_LONG_CYC) : 8'(`LDT_SLOW_SHORT_CYC);
                end
            end
        end else if (st.tdr == TDR_RUN) begin
            // Fast pulses count converter ticks, slow pulses count clocks
            if (st.pulseSlow || (st.pulseFast && adcStrobe)) begin
                next_st.pulseCnt = st.pulseCnt - 8'h01;
                if (st.pulseCnt == 8'h01) begin
                    next_st.pulseFast = 1'b0;
                    next_st.pulseSlow = 1'b0;
                end
            end
            if (adcStrobe) begin
                if (inWindow) begin
                    if (!st.peakSeen || level > orient(st.peakVal, st.rctrl[`LDT_B_MINMODE])) begin
                        next_st.peakSeen = 1'b1;
                        next_st.peakVal = adcSample;
                        next_st.peakTime = st.tick;
                    end
                    if (!st.thrHit && level > $signed({2'b00, st.rctrl[6:0]})) begin
                        next_st.thrHit = 1'b1;
                        next_st.thrTime = st.tick;
                    end
                end
                if (st.tick == `LDT_MON_LAST) begin
                    next_st.tdr = TDR_HOLD;
                end else begin
                    next_st.tick = st.tick + 8'h01;
                end
            end
        end

        // Self-test transmitter, bursts unless continuous
        next_st.burstCnt = bistRun ? st.burstCnt + 13'h0001 : 13'h0000;
        next_st.txValid = bistRun && (st.cont || !st.burstCnt[12]);
        next_st.txBit = txPred;
        // Self-test checker; a mis-compare in the restart cycle still counts
        if (bistStartWrite) begin
            next_st.failLatched = 1'b0;
            next_st.errCnt = 8'h00;
            next_st.seedCnt = 4'h0;
        end
        if (bistRun && rxValid && st.seedCnt != `LDT_BIST_SEED) begin
            next_st.seedCnt = st.seedCnt + 4'h1;
        end
        if (checkBit) begin
            if (rxBit != rxPred) begin
                next_st.failLatched = 1'b1;
                next_st.pass = 1'b0;
                if (next_st.errCnt != 8'hFF) begin
                    next_st.errCnt = next_st.errCnt + 8'h01;
                end
            end else if (!next_st.failLatched) begin
                next_st.pass = 1'b1;
            end
        end
    end

    // State register; thresholds open to the range extremes
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.rwin <= `LDT_RST_RWIN;
            st.thr <= {`LDT_SNR_MAX_BYTE, `LDT_S8_MAX, `LDT_S8_MIN, `LDT_S8_MAX, `LDT_S8_MIN,
                       `LDT_S8_MAX, `LDT_S8_MIN, `LDT_U8_MAX, `LDT_U8_MIN, `LDT_S8_MAX, `LDT_S8_MIN};
            st.pulseNeg <= 1'b1;
            st.tdr <= TDR_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign regRdData = st.rdData;
    assign qualityIrq = st.irq;
    assign tdrOwnsDrivers = st.rctrl[`LDT_B_ENABLE];
    assign fastDriverPulse = st.pulseFast;
    assign slowDriverPulse = st.pulseSlow;
    assign pulseNegative = st.pulseNeg;
    assign drivePairRx = st.rctrl[`LDT_B_DRVPAIR];
    assign monitorPairRx = st.rctrl[`LDT_B_MONPAIR];
    assign txBit = st.txBit;
    assign txValid = st.txValid;
    assign bistPass = st.pass;

    // Polarity of the previous fast pulse, for checking only
    logic prevNeg;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prevNeg <= 1'b1;
        end else if ($rose(st.pulseFast)) begin
            prevNeg <= st.pulseNeg;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence zeroLaunch;
        launch && st.rctrl[10:8] == 3'h0 && !regReq.write;
    endsequence
    sequence quietRun;
        st.tdr == TDR_RUN && !st.pulseFast && !st.pulseSlow;
    endsequence

    send_clear_a: assert property (launch && !regReq.write |=> !st.rctrl[`LDT_B_SEND])
        else $error("send bit did not clear on launch");
    blw_low_a: assert property ($rose(st.warn[4]) |-> $past($signed(params.blw) < $signed(st.thr[4])))
        else $error("wander low warning without strict underrun");
    blw_high_a: assert property ($rose(st.warn[5]) |-> $past($signed(params.blw) > $signed(st.thr[5])))
        else $error("wander high warning without signed overrun");
    gain_high_a: assert property ($rose(st.warn[3]) |-> $past(params.gain > st.thr[3]))
        else $error("gain warning without unsigned overrun");
    driver_owner_a: assert property (st.pulseFast |-> st.rctrl[`LDT_B_ENABLE] && st.rctrl[`LDT_B_FAST])
        else $error("fast driver pulsed without ownership");
    polarity_alt_a: assert property ($rose(st.pulseFast) |-> st.pulseNeg != prevNeg)
        else $error("fast pulses did not alternate");
    zero_width_a: assert property (zeroLaunch |=> quietRun ##1 !st.pulseFast)
        else $error("zero width launch sent a pulse");
    hold_results_a: assert property (st.tdr == TDR_HOLD && !launch |=> $stable(st.peakVal) && $stable(st.thrTime))
        else $error("results changed while held");
    fail_latch_a: assert property (st.failLatched && !bistStartWrite |=> !st.pass && st.failLatched)
        else $error("pass flag rose after mis-compare");
    irq_gate_a: assert property (!irqEnable |=> !qualityIrq)
        else $error("interrupt without enable");
endmodule
`default_nettype wire

// >>> tb/ldt_cable.sv
/*
 * Cable model: echoes driver pulses into converter samples, loops the
 * self-test stream back with optional bit flips.
 * Assumes the block clock and a 20 ns sample strobe every second cycle.
 */
`timescale 1ns/10ps
`default_nettype none
module ldt_cable #(parameter int ECHO = 40) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic fastDriverPulse,
    input wire logic slowDriverPulse,
    input wire logic txBit,
    input wire logic txValid,
    input wire logic flipBit,
    output logic [7:0] adcSample,
    output logic adcStrobe,
    output logic rxBit,
    output logic rxValid
);
    logic [8:0] tick;
    logic drvLast;
    // Tick restarts on a new pulse and saturates, so an old echo never repeats
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            adcStrobe <= 1'b0;
            tick <= 9'h1FF;
            drvLast <= 1'b0;
            rxBit <= 1'b0;
            rxValid <= 1'b0;
        end else begin
            adcStrobe <= ~adcStrobe;
            drvLast <= fastDriverPulse | slowDriverPulse;
            if ((fastDriverPulse | slowDriverPulse) & ~drvLast) begin
                tick <= 9'h000;
            end else if (adcStrobe && tick != 9'h1FF) begin
                tick <= tick + 9'h001;
            end
            rxBit <= txBit ^ flipBit;
            rxValid <= txValid;
        end
    end
    // Ramp into the echo; background toggles so a stale value cannot pass
    assign adcSample = (tick == 9'(ECHO)) ? 8'h60 : (tick == 9'(ECHO - 1)) ? 8'h30 : tick[0] ? 8'hFE : 8'h02;
endmodule
`default_nettype wire

// >>> tb/ldt_top_tb.sv
/*
 * Self-checking bench of the link diagnostic block.
 * Assumes the cable model beside it; inputs change on falling edges.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ldt_defines.svh"
module ldt_top_tb;
    import ldt_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    ldt_regreq_type regReq = '0;
    ldt_params_type params = '0;
    logic irqEnable = 1'b0;
    logic bistRun = 1'b0;
    logic bistStartWrite = 1'b0;
    logic longSequenceSelect = 1'b0;
    logic flipBit = 1'b0;
    logic [15:0] regRdData;
    logic [7:0] adcSample;
    logic qualityIrq, adcStrobe, tdrOwnsDrivers, fastDriverPulse, slowDriverPulse, pulseNegative;
    logic drivePairRx, monitorPairRx, rxBit, rxValid, txBit, txValid, bistPass;
    int nMismatch = 0;
    int nCompared = 0;

    always #5 clock = ~clock;

    ldt_top dut (.clock(clock), .nrst(nrst), .regReq(regReq), .regRdData(regRdData), .params(params),
        .irqEnable(irqEnable), .qualityIrq(qualityIrq), .adcSample(adcSample), .adcStrobe(adcStrobe),
        .tdrOwnsDrivers(tdrOwnsDrivers), .fastDriverPulse(fastDriverPulse), .slowDriverPulse(slowDriverPulse),
        .pulseNegative(pulseNegative), .drivePairRx(drivePairRx), .monitorPairRx(monitorPairRx),
        .bistRun(bistRun), .bistStartWrite(bistStartWrite), .longSequenceSelect(longSequenceSelect),
        .rxBit(rxBit), .rxValid(rxValid), .txBit(txBit), .txValid(txValid), .bistPass(bistPass));

    ldt_cable cable (.clock(clock), .nrst(nrst), .fastDriverPulse(fastDriverPulse),
        .slowDriverPulse(slowDriverPulse), .txBit(txBit), .txValid(txValid), .flipBit(flipBit),
        .adcSample(adcSample), .adcStrobe(adcStrobe), .rxBit(rxBit), .rxValid(rxValid));

    task automatic final_report;
        if (nMismatch == 0 && nCompared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nCompared++;
        if (got !== exp) begin
            nMismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Strobe is held across exactly one rising edge
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clock);
        regReq <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(negedge clock);
        regReq <= '0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge clock);
        regReq <= '{addr: a, wdata: 16'h0000, write: 1'b0, read: 1'b1};
        @(negedge clock);
        regReq <= '0;
        @(negedge clock);
        d = regRdData;
    endtask

    task automatic test_reset;
        logic [15:0] v;
        logic [7:0] e;
        rd(`LDT_OFF_RWIN, v);
        chk(v, `LDT_RST_RWIN);
        rd(`LDT_OFF_RCTRL, v);
        chk(v, 16'h0000);
        chk({15'h0, bistPass}, 16'h0000);
        for (int i = 0; i < 11; i++) begin
            e = (i == 10) ? 8'h90 : (i / 2 == 1) ? (i[0] ? 8'hFF : 8'h00) : (i[0] ? 8'h7F : 8'h80);
            wr(`LDT_OFF_QDATA, {4'h0, i[3:0], 8'h00});
            rd(`LDT_OFF_QDATA, v);
            chk(v, {4'h0, i[3:0], e});
        end
    endtask

    task automatic test_quality;
        logic [15:0] v;
        wr(`LDT_OFF_QDATA, 16'h14DA);
        rd(`LDT_OFF_QDATA, v);
        chk(v, 16'h04DA);
        wr(`LDT_OFF_QMON, 16'h8000);
        wr(`LDT_OFF_QDATA, 16'h1380);
        irqEnable <= 1'b1;
        params.blw <= 8'hDA;
        params.gain <= 8'h80;
        cyc(4);
        rd(`LDT_OFF_QMON, v);
        chk(v, 16'h8000);
        params.blw <= 8'hD9;
        params.gain <= 8'h81;
        cyc(4);
        chk({15'h0, qualityIrq}, 16'h0001);
        rd(`LDT_OFF_QMON, v);
        chk(v, 16'h8018);
        params.blw <= 8'h5C;
        params.gain <= 8'h00;
        cyc(4);
        rd(`LDT_OFF_QMON, v);
        rd(`LDT_OFF_QMON, v);
        chk(v, 16'h8000);
        chk({15'h0, qualityIrq}, 16'h0000);
        wr(`LDT_OFF_QDATA, 16'h2400);
        rd(`LDT_OFF_QDATA, v);
        chk({8'h00, v[7:0]}, 16'h005C);
        wr(`LDT_OFF_QDATA, 16'h1550);
        cyc(2);
        rd(`LDT_OFF_QMON, v);
        chk(v, 16'h8020);
        params.blw <= 8'h50;
        cyc(2);
        rd(`LDT_OFF_QMON, v);
        rd(`LDT_OFF_QMON, v);
        chk(v, 16'h8000);
    endtask

    // One measurement: count driver cycles, keep fast polarity, fetch results
    task automatic tdr_run(input logic [15:0] c, output int nf, output int ns, output logic ng,
                           output logic [15:0] pk, output logic [15:0] th);
        nf = 0;
        ns = 0;
        ng = 1'bx;
        wr(`LDT_OFF_RCTRL, c);
        repeat (700) begin
            @(negedge clock);
            nf += int'(fastDriverPulse === 1'b1);
            ns += int'(slowDriverPulse === 1'b1);
            if (fastDriverPulse === 1'b1) ng = pulseNegative;
        end
        rd(`LDT_OFF_RPEAK, pk);
        rd(`LDT_OFF_RTHR, th);
    endtask

    task automatic test_tdr;
        int nf, ns;
        logic ng;
        logic [15:0] pk, th, v;
        tdr_run(16'hC920, nf, ns, ng, pk, th);
        chk({15'h0, tdrOwnsDrivers}, 16'h0001);
        chk({15'h0, ng}, 16'h0000);
        chk({8'h00, pk[7:0]}, 16'h0060);
        chk({th[15:8] + 8'h01, th[7], 7'h00}, {pk[15:8], 8'h80});
        rd(`LDT_OFF_RCTRL, v);
        chk(v, 16'hC120);
        cyc(300);
        rd(`LDT_OFF_RPEAK, v);
        chk(v, pk);
        tdr_run(16'hCF20, nf, ns, ng, pk, th);
        chk({15'h0, ng}, 16'h0001);
        chk({15'h0, nf >= 13 && nf <= 14 && ns == 0}, 16'h0001);
        tdr_run(16'hC820, nf, ns, ng, pk, th);
        chk({15'h0, nf == 0 && ns == 0}, 16'h0001);
        chk({pk[7:0], th[7]}, {8'h02, 1'b0});
        tdr_run(16'hBBA0, nf, ns, ng, pk, th);
        chk(16'(ns), 16'(`LDT_SLOW_SHORT_CYC));
        chk({13'h0, drivePairRx, monitorPairRx, pulseNegative}, 16'h0007);
        chk({8'h00, pk[7:0]}, 16'h00FE);
        wr(`LDT_OFF_RWIN, 16'h3050);
        tdr_run(16'hC920, nf, ns, ng, pk, th);
        chk({pk[7:0], th[7]}, {8'h02, 1'b0});
        chk({15'h0, ng}, 16'h0000);
        wr(`LDT_OFF_RCTRL, 16'h0000);
        cyc(2);
        chk({15'h0, tdrOwnsDrivers}, 16'h0000);
    endtask

    task automatic test_bist;
        logic [15:0] v;
        int lows;
        logic [14:0] hist;
        int nb;
        int bad;
        for (int s = 0; s < 2; s++) begin
            // Sequence length only changes while stopped, as software would do it
            bistRun <= 1'b0;
            longSequenceSelect <= s[0];
            cyc(2);
            bistRun <= 1'b1;
            bistStartWrite <= 1'b1;
            cyc(1);
            bistStartWrite <= 1'b0;
            cyc(200);
            chk({14'h0, txValid, bistPass}, 16'h0003);
        end
        flipBit <= 1'b1;
        cyc(20);
        flipBit <= 1'b0;
        cyc(100);
        chk({15'h0, bistPass}, 16'h0000);
        rd(`LDT_OFF_DIAG, v);
        chk({15'h0, v[15:8] != 8'h00}, 16'h0001);
        bistStartWrite <= 1'b1;
        cyc(1);
        bistStartWrite <= 1'b0;
        cyc(100);
        rd(`LDT_OFF_DIAG, v);
        chk({v[15:8], 7'h00, bistPass}, 16'h0001);
        wr(`LDT_OFF_DIAG, 16'h0020);
        rd(`LDT_OFF_DIAG, v);
        chk(v, 16'h0020);
        lows = 0;
        nb = 0;
        bad = 0;
        hist = 15'h0;
        // Own model of the 15-stage recurrence judges the transmitted bits
        repeat (9000) begin
            @(negedge clock);
            lows += int'(txValid !== 1'b1);
            if (txValid === 1'b1) begin
                bad += int'(nb >= 15 && txBit !== (hist[14] ^ hist[13]));
                hist = {hist[13:0], txBit};
                nb++;
            end
        end
        chk(16'(lows), 16'h0000);
        chk({15'(bad), hist == 15'h0}, 16'h0000);
    endtask

    // Watchdog sized well above the scenarios' total run
    initial begin
        repeat (60000) @(posedge clock);
        nMismatch++;
        final_report;
    end

    initial begin
        repeat (10) @(negedge clock);
        nrst <= 1'b1;
        test_reset;
        test_quality;
        test_tdr;
        test_bist;
        final_report;
    end
endmodule
`default_nettype wire
